// [hw/lcc_bkpt_match.sv]
// Instruction and data breakpoint address/mask matcher
`timescale 1ns/1ps
module lcc_bkpt_match (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic we_i,
    input wire logic is_data_i,
    input wire logic is_mask_i,
    input wire logic [2:0] idx_i,
    input wire logic [63:0] wdata_i,
    input wire logic iaddr_vld_i,
    input wire logic [63:0] iaddr_i,
    input wire logic daddr_vld_i,
    input wire logic [63:0] daddr_i,
    output logic ihit_o,
    output logic dhit_o
);
    logic [63:0] ia_r [lcc_pkg::N_BKPT];
    logic [63:0] im_r [lcc_pkg::N_BKPT];
    logic [63:0] da_r [lcc_pkg::N_BKPT];
    logic [63:0] dm_r [lcc_pkg::N_BKPT];
    logic ihit_nxt;
    logic dhit_nxt;

    // Zero mask disables, so reset leaves none live
    function automatic logic hit(input logic [63:0] a,
                                 input logic [63:0] bp,
                                 input logic [63:0] m);
        hit = (m != 64'h0) && (((a ^ bp) & m) == 64'h0);
    endfunction

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < lcc_pkg::N_BKPT; i++) begin
                ia_r[i] <= 64'h0;
                im_r[i] <= 64'h0;
                da_r[i] <= 64'h0;
                dm_r[i] <= 64'h0;
            end
        end else if (we_i) begin
            case ({is_data_i, is_mask_i})
                2'b00: ia_r[idx_i] <= wdata_i;
                2'b01: im_r[idx_i] <= wdata_i;
                2'b10: da_r[idx_i] <= wdata_i;
                default: dm_r[idx_i] <= wdata_i;
            endcase
        end
    end

    always_comb begin
        ihit_nxt = 1'b0;
        dhit_nxt = 1'b0;
        for (int i = 0; i < lcc_pkg::N_BKPT; i++) begin
            ihit_nxt |= iaddr_vld_i & hit(iaddr_i, ia_r[i], im_r[i]);
            dhit_nxt |= daddr_vld_i & hit(daddr_i, da_r[i], dm_r[i]);
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ihit_o <= 1'b0;
            dhit_o <= 1'b0;
        end else begin
            ihit_o <= ihit_nxt;
            dhit_o <= dhit_nxt;
        end
    end
endmodule

// [hw/lcc_compat.sv]
// Legacy control register compatibility and interception unit
// Overview of operation
// RL1: Paging bit is storage; translation from native bits
// RL2: Fault-address move intercepts; read gives upper half
// RL3: Table-base move intercepts; read gives lower half
// RL4: Write-through and cache-disable bits are storage only
// RL5: Extension move intercepts; read gives upper flags
// RL6: Bits 32,33 steer legacy virtual interrupt extensions
// RL7: Bit 34 set faults user timestamp reads
// RL8: Debug-extensions bit is storage only
// RL9: Page-size and address-extension bits ignored
// RL10: Machine-check and global-page bits are storage
// RL11: Bit 40 clear faults legacy counter reads
// RL12: Bit 41 clear intercepts legacy SIMD instructions
// RL13: Bit 42 gates delivery of SIMD exceptions
// RL14: Legacy debug register access intercepts
// RL15: Native breakpoints and traps cover both sets
// RL16: Legacy memory-range register access intercepts
// RL17: Any model-specific space access intercepts
// RL18: Counter read returns monitor or faults zero
// RL19: Legacy writes to monitors always intercepted
// RL20: Legacy machine-check register access intercepts
// RL21: Flags readable always; write needs level zero
// RL22: Non-zero reserved flag bits fault on write
// RL23: Storage bits read back last native write
`timescale 1ns/1ps
module lcc_compat (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire lcc_pkg::lcc_nat_req_t nat_req_i,
    output logic nat_ack_o,
    output logic [63:0] nat_rdata_o,
    output lcc_pkg::lcc_fault_t nat_fault_o,
    input wire logic leg_vld_i,
    input wire lcc_pkg::lcc_leg_req_t leg_req_i,
    input wire logic secure_mon_i,
    input wire logic [7:0] pm_priv_i,
    output logic leg_done_o,
    output logic [63:0] leg_data_o,
    output lcc_pkg::lcc_fault_t leg_fault_o,
    input wire logic instr_translate_enable_i,
    input wire logic data_translate_enable_i,
    output logic [1:0] xlate_en_o,
    output lcc_pkg::lcc_leg_ctl_t leg_ctl_o,
    input wire logic simd_exc_i,
    output logic simd_exc_o,
    input wire logic iaddr_vld_i,
    input wire logic [63:0] iaddr_i,
    input wire logic daddr_vld_i,
    input wire logic [63:0] daddr_i,
    output logic ibkpt_o,
    output logic dbkpt_o,
    input wire logic ss_en_i,
    input wire logic tb_en_i,
    input wire logic retire_i,
    input wire logic taken_i,
    output logic ss_trap_o,
    output logic tb_trap_o
);
    logic [63:0] flags_r;
    logic [63:0] kps_r;
    logic [63:0] kca_r;
    logic [63:0] tsc_r;
    logic nat_wr_ok;
    lcc_pkg::lcc_fault_t nat_flt_nxt;
    logic [63:0] nat_rd_nxt;
    logic s1_vld_r;
    logic s1_cnt_r;
    lcc_pkg::lcc_fault_t s1_flt_r;
    logic [63:0] s1_data_r;
    lcc_pkg::lcc_fault_t leg_flt_nxt;
    logic [63:0] leg_dat_nxt;
    logic [63:0] cnt_rdata;
    logic bp_we;
    logic cnt_we;
    logic user_lvl;

    function automatic logic is_sel(input lcc_pkg::lcc_nat_req_t r,
                                    input lcc_pkg::lcc_sel_t s);
        is_sel = r.sel == s;
    endfunction

    // Native write checks: privilege first, then reserved bits
    always_comb begin
        nat_flt_nxt = lcc_pkg::FLT_NONE;
        if (nat_req_i.wr && is_sel(nat_req_i, lcc_pkg::SEL_FLG)) begin
            if (nat_req_i.cpl != lcc_pkg::CPL_KERNEL) begin
                nat_flt_nxt = lcc_pkg::FLT_PRIV_REG; // RL21
            end else if ((nat_req_i.wdata
                          & lcc_pkg::FLG_RSVD_MASK) != 64'h0) begin
                nat_flt_nxt = lcc_pkg::FLT_RSVD_REG; // RL22
            end
        end
    end

    assign nat_wr_ok = nat_req_i.wr && (nat_flt_nxt == lcc_pkg::FLT_NONE);

    // Plain storage, no flush side effects
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            flags_r <= lcc_pkg::FLG_RST;
        end else if (nat_wr_ok && is_sel(nat_req_i, lcc_pkg::SEL_FLG)) begin
            flags_r <= nat_req_i.wdata; // RL1 RL5 RL8 RL9 RL10 RL23
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            kps_r <= lcc_pkg::KR_RST;
        end else if (nat_wr_ok && is_sel(nat_req_i, lcc_pkg::SEL_KPS)) begin
            kps_r <= nat_req_i.wdata; // RL3
        end
    end

    // Cache attribute bits drive no cache logic
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            kca_r <= lcc_pkg::KR_RST;
        end else if (nat_wr_ok && is_sel(nat_req_i, lcc_pkg::SEL_KCA)) begin
            kca_r <= nat_req_i.wdata; // RL4 RL23
        end
    end

    // No privilege check on reads
    always_comb begin
        case (nat_req_i.sel)
            lcc_pkg::SEL_FLG: nat_rd_nxt = flags_r; // RL21 RL23
            lcc_pkg::SEL_KPS: nat_rd_nxt = kps_r;
            lcc_pkg::SEL_KCA: nat_rd_nxt = kca_r; // RL4
            default: nat_rd_nxt = 64'h0;
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            nat_ack_o <= 1'b0;
            nat_rdata_o <= 64'h0;
            nat_fault_o <= lcc_pkg::FLT_NONE;
        end else begin
            nat_ack_o <= nat_req_i.wr | nat_req_i.rd;
            nat_fault_o <= nat_flt_nxt;
            if (nat_req_i.rd) begin
                nat_rdata_o <= nat_rd_nxt;
            end
        end
    end

    // Free-running time stamp for legacy reads
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tsc_r <= 64'h0;
        end else begin
            tsc_r <= tsc_r + 64'h1;
        end
    end

    assign bp_we = nat_req_i.wr
                 && (nat_req_i.cpl == lcc_pkg::CPL_KERNEL)
                 && (nat_req_i.sel inside {lcc_pkg::SEL_IBR_A,
                     lcc_pkg::SEL_IBR_M, lcc_pkg::SEL_DBR_A,
                     lcc_pkg::SEL_DBR_M});
    assign cnt_we = nat_req_i.wr
                  && (nat_req_i.cpl == lcc_pkg::CPL_KERNEL)
                  && is_sel(nat_req_i, lcc_pkg::SEL_CNT);

    // Matcher has no notion of instruction set
    lcc_bkpt_match u_bkpt (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .we_i(bp_we),
        .is_data_i(nat_req_i.sel == lcc_pkg::SEL_DBR_A
                   || nat_req_i.sel == lcc_pkg::SEL_DBR_M),
        .is_mask_i(nat_req_i.sel == lcc_pkg::SEL_IBR_M
                   || nat_req_i.sel == lcc_pkg::SEL_DBR_M),
        .idx_i(nat_req_i.idx),
        .wdata_i(nat_req_i.wdata),
        .iaddr_vld_i(iaddr_vld_i),
        .iaddr_i(iaddr_i), // RL15
        .daddr_vld_i(daddr_vld_i),
        .daddr_i(daddr_i),
        .ihit_o(ibkpt_o),
        .dhit_o(dbkpt_o)
    );

    // Legacy has no count write path
    lcc_count_mem u_cnt (
        .clk_i(clk_i),
        .we_i(cnt_we), // RL19
        .waddr_i(nat_req_i.idx),
        .wdata_i(nat_req_i.wdata),
        .raddr_i(leg_req_i.idx), // RL18
        .rdata_o(cnt_rdata)
    );

    assign user_lvl = leg_req_i.cpl != lcc_pkg::CPL_KERNEL;

    // Legacy decision, one request per cycle
    always_comb begin
        leg_flt_nxt = lcc_pkg::FLT_NONE;
        leg_dat_nxt = 64'h0;
        case (leg_req_i.op)
            lcc_pkg::OP_RD_BAS: begin
                leg_dat_nxt = {32'h0,
                               flags_r[31:0] & lcc_pkg::BAS_RD_MASK};
            end
            lcc_pkg::OP_RD_FLA: begin
                leg_dat_nxt = {32'h0, kps_r[63:32]}; // RL2
            end
            lcc_pkg::OP_RD_TBL: begin
                leg_dat_nxt = {32'h0, kps_r[31:0]}; // RL3
            end
            lcc_pkg::OP_RD_EXT: begin
                leg_dat_nxt = {32'h0, flags_r[63:32]}; // RL5
            end
            lcc_pkg::OP_WR_BAS: begin
                leg_flt_nxt = lcc_pkg::FLT_INTERCEPT;
            end
            lcc_pkg::OP_WR_FLA: begin
                leg_flt_nxt = lcc_pkg::FLT_INTERCEPT; // RL2
            end
            lcc_pkg::OP_WR_TBL: begin
                leg_flt_nxt = lcc_pkg::FLT_INTERCEPT; // RL3
            end
            lcc_pkg::OP_WR_EXT: begin
                leg_flt_nxt = lcc_pkg::FLT_INTERCEPT; // RL5
            end
            lcc_pkg::OP_DBG: begin
                leg_flt_nxt = lcc_pkg::FLT_INTERCEPT; // RL14
            end
            lcc_pkg::OP_MSR_RD: begin
                leg_flt_nxt = lcc_pkg::FLT_INTERCEPT; // RL17
            end
            lcc_pkg::OP_MSR_WR: begin
                leg_flt_nxt = lcc_pkg::FLT_INTERCEPT; // RL17 RL19
            end
            lcc_pkg::OP_MTRR: begin
                leg_flt_nxt = lcc_pkg::FLT_INTERCEPT; // RL16
            end
            lcc_pkg::OP_MCR: begin
                leg_flt_nxt = lcc_pkg::FLT_INTERCEPT; // RL20
            end
            lcc_pkg::OP_TSC: begin
                if (user_lvl && flags_r[lcc_pkg::TSD_BIT]) begin
                    leg_flt_nxt = lcc_pkg::FLT_GP; // RL7
                end else begin
                    leg_dat_nxt = tsc_r;
                end
            end
            lcc_pkg::OP_CNT: begin
                // Any one securing condition blocks the read
                if (secure_mon_i
                    || !flags_r[lcc_pkg::PCE_BIT]
                    || pm_priv_i[leg_req_i.idx]) begin
                    leg_flt_nxt = lcc_pkg::FLT_GP; // RL11 RL18
                end
            end
            lcc_pkg::OP_SIMD: begin
                if (!flags_r[lcc_pkg::SIMD_CTX_BIT]) begin
                    leg_flt_nxt = lcc_pkg::FLT_INTERCEPT; // RL12
                end
            end
            default: begin
                leg_flt_nxt = lcc_pkg::FLT_INTERCEPT;
            end
        endcase
    end

    // Stage waits for registered count read
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s1_vld_r <= 1'b0;
            s1_cnt_r <= 1'b0;
            s1_flt_r <= lcc_pkg::FLT_NONE;
            s1_data_r <= 64'h0;
        end else begin
            s1_vld_r <= leg_vld_i;
            s1_cnt_r <= leg_vld_i
                      && (leg_req_i.op == lcc_pkg::OP_CNT)
                      && (leg_flt_nxt == lcc_pkg::FLT_NONE);
            s1_flt_r <= leg_vld_i ? leg_flt_nxt : lcc_pkg::FLT_NONE;
            s1_data_r <= leg_vld_i ? leg_dat_nxt : 64'h0;
        end
    end

    // Faulted requests return zero data
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            leg_done_o <= 1'b0;
            leg_fault_o <= lcc_pkg::FLT_NONE;
            leg_data_o <= 64'h0;
        end else begin
            leg_done_o <= s1_vld_r;
            leg_fault_o <= s1_flt_r;
            leg_data_o <= s1_cnt_r ? cnt_rdata : s1_data_r; // RL18
        end
    end

    // Translation ignores the paging and extension flags
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            xlate_en_o <= 2'b00;
        end else begin
            xlate_en_o <= {instr_translate_enable_i,
                           data_translate_enable_i}; // RL1 RL9
        end
    end

    // Controls consumed only by the legacy decoder
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            leg_ctl_o <= '0;
        end else begin
            leg_ctl_o.vme <= flags_r[lcc_pkg::VME_BIT]; // RL6
            leg_ctl_o.pvi <= flags_r[lcc_pkg::PVI_BIT]; // RL6
            leg_ctl_o.simd_ctx <= flags_r[lcc_pkg::SIMD_CTX_BIT]; // RL12
        end
    end

    // Masked exceptions are dropped, not held for later
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            simd_exc_o <= 1'b0;
        end else begin
            simd_exc_o <= simd_exc_i
                        & flags_r[lcc_pkg::SIMD_EXC_BIT]; // RL13
        end
    end

    // Traps fire for whichever instruction set retired
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ss_trap_o <= 1'b0;
            tb_trap_o <= 1'b0;
        end else begin
            ss_trap_o <= ss_en_i & retire_i; // RL15
            tb_trap_o <= tb_en_i & taken_i; // RL15
        end
    end
endmodule

// [hw/lcc_count_mem.sv]
// Monitor count storage with registered read data
`timescale 1ns/1ps
module lcc_count_mem (
    input wire logic clk_i,
    input wire logic we_i,
    input wire logic [2:0] waddr_i,
    input wire logic [63:0] wdata_i,
    input wire logic [2:0] raddr_i,
    output logic [63:0] rdata_o
);
    logic [63:0] mem_r [lcc_pkg::N_MON];

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem_r[waddr_i] <= wdata_i;
        end
    end

    // Read before write on a same-address collision
    always_ff @(posedge clk_i) begin
        rdata_o <= mem_r[raddr_i];
    end
endmodule

// [shared/lcc_pkg.sv]
// Constants and types for the legacy control register compatibility block
package lcc_pkg;
    localparam int PG_BIT = 31;
    localparam int DE_BIT = 25;
    localparam int VME_BIT = 32;
    localparam int PVI_BIT = 33;
    localparam int TSD_BIT = 34;
    localparam int PSE_BIT = 36;
    localparam int PAE_BIT = 37;
    localparam int MCE_BIT = 38;
    localparam int PGE_BIT = 39;
    localparam int PCE_BIT = 40;
    localparam int SIMD_CTX_BIT = 41;
    localparam int SIMD_EXC_BIT = 42;
    localparam int PWT_BIT = 3;
    localparam int PCD_BIT = 4;
    localparam logic [63:0] FLG_RSVD_MASK = 64'hfffff80000000000;
    localparam logic [31:0] BAS_RD_MASK = 32'hfffffe3f;
    localparam logic [63:0] FLG_RST = 64'h0000000000000000;
    localparam logic [63:0] KR_RST = 64'h0000000000000000;
    localparam logic [1:0] CPL_KERNEL = 2'h0;
    localparam int N_BKPT = 8;
    localparam int N_MON = 8;
    localparam int LEG_LAT = 2;

    typedef enum logic [2:0] {
        SEL_FLG = 3'b000,
        SEL_KPS = 3'b001,
        SEL_KCA = 3'b010,
        SEL_IBR_A = 3'b011,
        SEL_IBR_M = 3'b100,
        SEL_DBR_A = 3'b101,
        SEL_DBR_M = 3'b110,
        SEL_CNT = 3'b111
    } lcc_sel_t;

    typedef enum logic [3:0] {
        OP_RD_BAS = 4'b0000,
        OP_WR_BAS = 4'b0001,
        OP_RD_FLA = 4'b0010,
        OP_WR_FLA = 4'b0011,
        OP_RD_TBL = 4'b0100,
        OP_WR_TBL = 4'b0101,
        OP_RD_EXT = 4'b0110,
        OP_WR_EXT = 4'b0111,
        OP_DBG = 4'b1000,
        OP_MSR_RD = 4'b1001,
        OP_MSR_WR = 4'b1010,
        OP_MTRR = 4'b1011,
        OP_MCR = 4'b1100,
        OP_TSC = 4'b1101,
        OP_CNT = 4'b1110,
        OP_SIMD = 4'b1111
    } lcc_op_t;

    typedef enum logic [2:0] {
        FLT_NONE = 3'b000,
        FLT_INTERCEPT = 3'b001,
        FLT_GP = 3'b010,
        FLT_PRIV_REG = 3'b011,
        FLT_RSVD_REG = 3'b100
    } lcc_fault_t;

    typedef struct packed {
        logic wr;
        logic rd;
        lcc_sel_t sel;
        logic [2:0] idx;
        logic [1:0] cpl;
        logic [63:0] wdata;
    } lcc_nat_req_t;

    typedef struct packed {
        lcc_op_t op;
        logic [1:0] cpl;
        logic [2:0] idx;
    } lcc_leg_req_t;

    typedef struct packed {
        logic vme;
        logic pvi;
        logic simd_ctx;
    } lcc_leg_ctl_t;
endpackage

// [sim/lcc_compat_assertions.sv]
// Port-level assertions for the legacy control compatibility unit
`timescale 1ns/1ps
module lcc_compat_assertions (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire lcc_pkg::lcc_nat_req_t nat_req_i,
    input wire logic nat_ack_o,
    input wire lcc_pkg::lcc_fault_t nat_fault_o,
    input wire logic leg_vld_i,
    input wire lcc_pkg::lcc_leg_req_t leg_req_i,
    input wire logic secure_mon_i,
    input wire logic [7:0] pm_priv_i,
    input wire logic leg_done_o,
    input wire logic [63:0] leg_data_o,
    input wire lcc_pkg::lcc_fault_t leg_fault_o,
    input wire logic instr_translate_enable_i,
    input wire logic data_translate_enable_i,
    input wire logic [1:0] xlate_en_o,
    input wire lcc_pkg::lcc_leg_ctl_t leg_ctl_o,
    input wire logic simd_exc_i,
    input wire logic simd_exc_o,
    input wire logic iaddr_vld_i,
    input wire logic ibkpt_o,
    input wire logic ss_en_i,
    input wire logic retire_i,
    input wire logic ss_trap_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_priv_write_fault: assert property (
        nat_req_i.wr && nat_req_i.sel == lcc_pkg::SEL_FLG &&
        nat_req_i.cpl != lcc_pkg::CPL_KERNEL
        |=> nat_ack_o && nat_fault_o == lcc_pkg::FLT_PRIV_REG)
        else $error("flag write at user level not refused");
    chk_rsvd_write_fault: assert property (
        nat_req_i.wr && nat_req_i.sel == lcc_pkg::SEL_FLG &&
        nat_req_i.cpl == lcc_pkg::CPL_KERNEL &&
        (nat_req_i.wdata & lcc_pkg::FLG_RSVD_MASK) != 64'h0
        |=> nat_ack_o && nat_fault_o == lcc_pkg::FLT_RSVD_REG)
        else $error("reserved flag bits accepted");
    chk_read_no_fault: assert property (
        nat_req_i.rd && !nat_req_i.wr
        |=> nat_ack_o && nat_fault_o == lcc_pkg::FLT_NONE)
        else $error("native read faulted or unanswered");
    chk_leg_intercept: assert property (
        leg_vld_i && leg_req_i.op inside {lcc_pkg::OP_WR_BAS,
        lcc_pkg::OP_WR_FLA, lcc_pkg::OP_WR_TBL, lcc_pkg::OP_WR_EXT,
        lcc_pkg::OP_DBG, lcc_pkg::OP_MSR_RD, lcc_pkg::OP_MSR_WR,
        lcc_pkg::OP_MTRR, lcc_pkg::OP_MCR}
        |-> ##2 leg_done_o && leg_fault_o == lcc_pkg::FLT_INTERCEPT &&
        leg_data_o == 64'h0)
        else $error("legacy access not intercepted");
    chk_simd_gate: assert property (
        leg_vld_i && leg_req_i.op == lcc_pkg::OP_SIMD |=> ##1
        leg_done_o && leg_fault_o == ($past(leg_ctl_o.simd_ctx) ?
        lcc_pkg::FLT_NONE : lcc_pkg::FLT_INTERCEPT))
        else $error("simd gating wrong");
    chk_pmc_secured: assert property (
        leg_vld_i && leg_req_i.op == lcc_pkg::OP_CNT &&
        (secure_mon_i || pm_priv_i[leg_req_i.idx])
        |-> ##2 leg_done_o && leg_fault_o == lcc_pkg::FLT_GP &&
        leg_data_o == 64'h0)
        else $error("secured counter read not refused");
    chk_done_origin: assert property (
        leg_done_o |-> $past(leg_vld_i, 2))
        else $error("legacy done without request");
    chk_xlate_follow: assert property (
        1'b1 |=> xlate_en_o ==
        $past({instr_translate_enable_i, data_translate_enable_i}))
        else $error("translation enable not from native bits");
    chk_simd_exc_quiet: assert property (
        !simd_exc_i |=> !simd_exc_o)
        else $error("simd exception without cause");
    chk_step_trap: assert property (
        1'b1 |=> ss_trap_o == $past(ss_en_i && retire_i))
        else $error("single step trap wrong");
    chk_bkpt_valid: assert property (
        !iaddr_vld_i |=> !ibkpt_o)
        else $error("breakpoint without address");

    cover property (leg_vld_i && leg_req_i.op == lcc_pkg::OP_CNT ##2
        leg_done_o && leg_fault_o == lcc_pkg::FLT_NONE);
    cover property (nat_ack_o && nat_fault_o == lcc_pkg::FLT_PRIV_REG);
    cover property (ibkpt_o);
endmodule

bind lcc_compat lcc_compat_assertions u_chk (.*);

// [sim/test_lcc_compat.sv]
// Random self-checking bench for the legacy control compatibility unit
`timescale 1ns/1ps
module test_lcc_compat;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    lcc_pkg::lcc_nat_req_t nat_req_i = '0;
    lcc_pkg::lcc_leg_req_t leg_req_i = '0;
    logic leg_vld_i = 1'b0, secure_mon_i = 1'b0, simd_exc_i = 1'b0;
    logic instr_translate_enable_i = 1'b0, data_translate_enable_i = 1'b0;
    logic iaddr_vld_i = 1'b0, daddr_vld_i = 1'b0, ss_en_i = 1'b0;
    logic tb_en_i = 1'b0, retire_i = 1'b0, taken_i = 1'b0;
    logic [7:0] pm_priv_i = 8'h00;
    logic [63:0] iaddr_i = 64'h0, daddr_i = 64'h0;
    logic nat_ack_o, leg_done_o, simd_exc_o, ibkpt_o, dbkpt_o;
    logic ss_trap_o, tb_trap_o;
    logic [63:0] nat_rdata_o, leg_data_o;
    lcc_pkg::lcc_fault_t nat_fault_o, leg_fault_o;
    logic [1:0] xlate_en_o;
    lcc_pkg::lcc_leg_ctl_t leg_ctl_o;
    int failures = 0, n_tests = 0;
    logic [63:0] seed = 64'h6;
    // Model: ba[3..6] breakpoints, ba[7] counts
    logic [63:0] flg, kps, kca, tsc, e_rd, ld;
    logic [63:0] ba [8][8];
    logic e_ack;
    lcc_pkg::lcc_fault_t e_nf, lf;
    logic [67:0] s_lg, e_lg;
    logic [6:0] e_a;
    logic [2:0] e_b;

    lcc_compat dut_u (.*);

    initial begin
        forever #50 clk_i = ~clk_i;
    end

    function automatic logic [63:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 7;
        seed ^= seed << 17;
        return seed;
    endfunction

    function automatic logic hit(input int a, input logic [63:0] x);
        hit = 1'b0;
        for (int k = 0; k < 8; k++) begin
            if (ba[a+1][k] != 64'h0 && ((x ^ ba[a][k]) & ba[a+1][k]) == 0)
                hit = 1'b1;
        end
    endfunction

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time,
                seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        if (failures == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Fill mode loads every count entry first
    task automatic step(input logic fill, input logic [2:0] fi);
        lcc_pkg::lcc_nat_req_t n;
        lcc_pkg::lcc_leg_req_t l;
        logic [63:0] r, w;
        r = rnd();
        w = rnd();
        n.wr = fill | (r[0] & r[1]);
        n.rd = ~fill & r[2];
        n.sel = fill ? lcc_pkg::SEL_CNT : lcc_pkg::lcc_sel_t'(r[5:3]);
        n.idx = fill ? fi : r[8:6];
        n.cpl = (r[9] & r[10] & ~fill) ? r[12:11] : lcc_pkg::CPL_KERNEL;
        n.wdata = r[13] ? w : w & ~lcc_pkg::FLG_RSVD_MASK;
        l = lcc_pkg::lcc_leg_req_t'(r[23:15]);
        @(posedge clk_i);
        nat_req_i <= n;
        leg_req_i <= l;
        leg_vld_i <= r[14] & ~fill;
        secure_mon_i <= r[24] & r[25];
        pm_priv_i <= w[7:0] & w[15:8];
        {simd_exc_i, data_translate_enable_i,
            instr_translate_enable_i} <= r[28:26];
        {taken_i, retire_i, tb_en_i, ss_en_i} <= r[32:29];
        {daddr_vld_i, iaddr_vld_i} <= r[34:33];
        iaddr_i <= r[35] ? ba[3][l.idx] ^ (w & ~ba[4][l.idx]) : w;
        daddr_i <= r[36] ? ba[5][n.idx] ^ (r & ~ba[6][n.idx]) : r;
    endtask

    always @(posedge clk_i) begin
        if (rst_i) begin
            {flg, kps, kca, tsc, e_rd} = 320'h0;
            {e_ack, s_lg, e_lg, e_a, e_b} = 147'h0;
            e_nf = lcc_pkg::FLT_NONE;
            for (int i = 0; i < 8; i++) begin
                for (int j = 3; j < 7; j++)
                    ba[j][i] = 64'h0;
            end
        end else begin
            e_a = {instr_translate_enable_i, data_translate_enable_i,
                flg[lcc_pkg::VME_BIT], flg[lcc_pkg::PVI_BIT],
                flg[lcc_pkg::SIMD_CTX_BIT], ss_en_i & retire_i,
                tb_en_i & taken_i};
            e_b = {simd_exc_i & flg[lcc_pkg::SIMD_EXC_BIT],
                iaddr_vld_i & hit(3, iaddr_i),
                daddr_vld_i & hit(5, daddr_i)};
            e_lg = s_lg;
            lf = lcc_pkg::FLT_NONE;
            ld = 64'h0;
            case (leg_req_i.op)
                lcc_pkg::OP_RD_BAS: ld = {32'h0,
                    flg[31:0] & lcc_pkg::BAS_RD_MASK};
                lcc_pkg::OP_RD_FLA: ld = {32'h0, kps[63:32]};
                lcc_pkg::OP_RD_TBL: ld = {32'h0, kps[31:0]};
                lcc_pkg::OP_RD_EXT: ld = {32'h0, flg[63:32]};
                lcc_pkg::OP_TSC: begin
                    if (leg_req_i.cpl != 2'h0 && flg[lcc_pkg::TSD_BIT])
                        lf = lcc_pkg::FLT_GP;
                    else
                        ld = tsc;
                end
                lcc_pkg::OP_CNT: begin
                    if (secure_mon_i || !flg[lcc_pkg::PCE_BIT] ||
                        pm_priv_i[leg_req_i.idx])
                        lf = lcc_pkg::FLT_GP;
                    else
                        ld = ba[7][leg_req_i.idx];
                end
                lcc_pkg::OP_SIMD: begin
                    if (!flg[lcc_pkg::SIMD_CTX_BIT])
                        lf = lcc_pkg::FLT_INTERCEPT;
                end
                default: lf = lcc_pkg::FLT_INTERCEPT;
            endcase
            s_lg = leg_vld_i ? {1'b1, lf, ld} : 68'h0;
            tsc = tsc + 64'h1;
            e_ack = nat_req_i.wr | nat_req_i.rd;
            e_nf = lcc_pkg::FLT_NONE;
            if (nat_req_i.rd)
                e_rd = nat_req_i.sel == lcc_pkg::SEL_FLG ? flg :
                    nat_req_i.sel == lcc_pkg::SEL_KPS ? kps :
                    nat_req_i.sel == lcc_pkg::SEL_KCA ? kca : 64'h0;
            if (nat_req_i.wr) begin
                if (nat_req_i.sel == lcc_pkg::SEL_KPS)
                    kps = nat_req_i.wdata;
                else if (nat_req_i.sel == lcc_pkg::SEL_KCA)
                    kca = nat_req_i.wdata;
                else if (nat_req_i.sel != lcc_pkg::SEL_FLG) begin
                    if (nat_req_i.cpl == lcc_pkg::CPL_KERNEL)
                        ba[nat_req_i.sel][nat_req_i.idx] = nat_req_i.wdata;
                end else if (nat_req_i.cpl != lcc_pkg::CPL_KERNEL)
                    e_nf = lcc_pkg::FLT_PRIV_REG;
                else if ((nat_req_i.wdata & lcc_pkg::FLG_RSVD_MASK) != 0)
                    e_nf = lcc_pkg::FLT_RSVD_REG;
                else
                    flg = nat_req_i.wdata;
            end
        end
    end

    always @(negedge clk_i) begin
        if (!rst_i) begin
            chk(64'({nat_ack_o, nat_fault_o}), 64'({e_ack, e_nf}));
            chk(nat_rdata_o, e_rd);
            chk(64'({leg_done_o, leg_fault_o}), 64'(e_lg[67:64]));
            chk(leg_data_o, e_lg[63:0]);
            chk(64'({xlate_en_o, leg_ctl_o, ss_trap_o, tb_trap_o}),
                64'(e_a));
            chk(64'({simd_exc_o, ibkpt_o, dbkpt_o}), 64'(e_b));
        end
    end

    // Reset moves off the sampling edge
    initial begin
        repeat (10) @(negedge clk_i);
        rst_i = 1'b0;
        for (int k = 0; k < 8; k++)
            step(1'b1, 3'(k));
        repeat (3000) step(1'b0, 3'h0);
        @(negedge clk_i);
        rst_i = 1'b1;
        repeat (3) @(negedge clk_i);
        rst_i = 1'b0;
        repeat (3000) step(1'b0, 3'h0);
        tally_and_finish();
    end

    initial begin
        #800000;
        failures++;
        tally_and_finish();
    end
endmodule
